// File: rtl/spc_pkg.sv
// constants for the serial port control block
// assumes ref_clk is the oscillator and one machine cycle is twelve periods
package spc_pkg;
    // ==========================================
    // register addresses and reset value
    localparam logic [7:0] CTRL_ADDR  = 8'h98;
    localparam logic [7:0] DATA_ADDR  = 8'h99;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_NONE  = 8'h00;
    // ==========================================
    // serial_control_reg field positions
    localparam int CTL_RI  = 0;
    localparam int CTL_TI  = 1;
    localparam int CTL_RB8 = 2;
    localparam int CTL_TB8 = 3;
    localparam int CTL_REN = 4;
    localparam int CTL_SM2 = 5;
    localparam int CTL_SML = 6;
    localparam int CTL_SMH = 7;
    // ==========================================
    // operating modes {mode_select_high, mode_select_low}
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_A10  = 2'h1;
    localparam logic [1:0] MODE_A11F = 2'h2;
    localparam logic [1:0] MODE_A11T = 2'h3;
    // ==========================================
    // machine cycle slot indices, two slots per state
    localparam logic [3:0] MC_LAST   = 4'hb;
    localparam logic [3:0] IDX_STATE_ONE_PHASE_ONE  = 4'h0;
    localparam logic [3:0] IDX_STATE_THREE_PHASE_ONE  = 4'h4;
    localparam logic [3:0] IDX_S5P2  = 4'h9;
    localparam logic [3:0] IDX_STATE_SIX_PHASE_TWO  = 4'hb;
    // ==========================================
    // mode 0 sequence counts
    localparam logic [3:0] M0_LOAD   = 4'ha;
    localparam logic [3:0] M0_ONE    = 4'h1;
    localparam logic [3:0] M0_ZERO   = 4'h0;
    localparam logic [3:0] M0_TX_CLK = 4'h8;
    localparam logic [3:0] M0_RX_CLK = 4'h9;
    localparam logic [3:0] M0_RX_END = 4'h2;
    // ==========================================
    // asynchronous bit timing in baud generator ticks
    localparam logic [3:0] BIT_LAST  = 4'hf;
    localparam logic [3:0] SAMP_A    = 4'h7;
    localparam logic [3:0] SAMP_C    = 4'h9;
    localparam logic [1:0] M2_SLOW   = 2'h3;
    localparam logic [1:0] M2_FAST   = 2'h1;
    localparam logic [3:0] A10_BITS  = 4'ha;
    localparam logic [3:0] A11_BITS  = 4'hb;
    localparam logic [3:0] STOP_A10  = 4'h9;
    localparam logic [3:0] STOP_A11  = 4'ha;
    // ==========================================
    // receive framing states
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b01,
        RX_FRAME = 2'b10
    } spc_rx_st_t;
endpackage : spc_pkg

// File: rtl/spc_mc_timing.sv
// machine cycle framing: twelve oscillator periods, six states of two phases
// assumes a free running ref_clk and asynchronous active low reset
module spc_mc_timing (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // timing points
    output logic      state_one_phase_one,
    output logic      state_three_phase_one,
    output logic      state_six_phase_two,
    output logic      s3_to_s5
);
    // ==========================================
    // slot counter
    logic [3:0] slot_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_r <= 4'h0;
        end else if (slot_r == spc_pkg::MC_LAST) begin
            slot_r <= 4'h0;
        end else begin
            slot_r <= slot_r + 4'h1;
        end
    end

    // ==========================================
    // decoded points
    assign state_one_phase_one     = (slot_r == spc_pkg::IDX_STATE_ONE_PHASE_ONE);
    assign state_three_phase_one     = (slot_r == spc_pkg::IDX_STATE_THREE_PHASE_ONE);
    assign state_six_phase_two     = (slot_r == spc_pkg::IDX_STATE_SIX_PHASE_TWO);
    assign s3_to_s5 = (slot_r >= spc_pkg::IDX_STATE_THREE_PHASE_ONE) && (slot_r <= spc_pkg::IDX_S5P2);
endmodule // spc_mc_timing

// File: rtl/spc_serial_port.sv
// serial port: control register, mode 0 shifter, asynchronous shifter, baud clocks
// assumes an sfr port with one-cycle strobes and timer 1 overflow from outside
module spc_serial_port (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // sfr access
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // baud sources
    input  wire logic       baud_doubler_bit,
    input  wire logic       timer1_overflow,
    // serial pins
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd_out,
    // interrupt request
    output logic            serial_irq
);
    // ==========================================
    // declarations
    logic [7:0] ctrl_r;
    logic [7:0] rx_buf_r;
    logic [7:0] rdata_r;
    logic [1:0] mode;
    logic       mode0;
    logic       ctrl_wr;
    logic       data_wr;
    logic       state_one_phase_one;
    logic       state_three_phase_one;
    logic       state_six_phase_two;
    logic       s3_to_s5;
    logic       ti_set;
    logic       ri_set;
    logic       rb8_set;
    logic       rb8_val;
    logic       buf_load;
    logic [7:0] buf_val;
    logic [8:0] m0_tx_r;
    logic [3:0] m0_tx_cnt_r;
    logic [7:0] m0_rx_r;
    logic [3:0] m0_rx_cnt_r;
    logic       m0_out_r;
    logic       shift_clock_out_r;
    logic [1:0] m2_div_r;
    logic       ovf_half_r;
    logic       brg_tick;
    logic [3:0] tx16_r;
    logic [10:0] a_tx_r;
    logic [3:0] a_tx_bits_r;
    logic       a_txd_r;
    spc_pkg::spc_rx_st_t rx_st_r;
    logic [3:0] rx16_r;
    logic [3:0] rx_idx_r;
    logic [1:0] samp_r;
    logic [8:0] a_rx_r;
    logic       rx_prev_r;
    logic       bit_v;
    logic [3:0] stop_idx;
    logic       key_bit;

    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    assign mode    = {ctrl_r[spc_pkg::CTL_SMH], ctrl_r[spc_pkg::CTL_SML]};
    assign mode0   = (mode == spc_pkg::MODE_SYNC);
    assign ctrl_wr = sfr_wr && (sfr_addr == spc_pkg::CTRL_ADDR);
    assign data_wr = sfr_wr && (sfr_addr == spc_pkg::DATA_ADDR);

    spc_mc_timing u_timing (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .state_one_phase_one     (state_one_phase_one),
        .state_three_phase_one     (state_three_phase_one),
        .state_six_phase_two     (state_six_phase_two),
        .s3_to_s5 (s3_to_s5)
    );

    // ==========================================
    // control register, hardware sets win over software writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= spc_pkg::CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_wr ? sfr_wdata : ctrl_r;
            if (ti_set) begin
                ctrl_r[spc_pkg::CTL_TI] <= 1'b1;
            end
            if (ri_set) begin
                ctrl_r[spc_pkg::CTL_RI] <= 1'b1;
            end
            if (rb8_set) begin
                ctrl_r[spc_pkg::CTL_RB8] <= rb8_val;
            end
        end
    end

    // ==========================================
    // receive buffer and read data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_r <= 8'h00;
        end else if (buf_load) begin
            rx_buf_r <= buf_val;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= spc_pkg::READ_NONE;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                spc_pkg::CTRL_ADDR: rdata_r <= ctrl_r;
                spc_pkg::DATA_ADDR: rdata_r <= rx_buf_r;
                default:            rdata_r <= spc_pkg::READ_NONE;
            endcase
        end
    end

    assign sfr_rdata  = rdata_r;
    assign serial_irq = ctrl_r[spc_pkg::CTL_TI] | ctrl_r[spc_pkg::CTL_RI];

    // ==========================================
    // mode 0 transmit: one shift per machine cycle at state six phase two
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            m0_tx_r     <= 9'h000;
            m0_tx_cnt_r <= spc_pkg::M0_ZERO;
            m0_out_r    <= 1'b1;
        end else if (data_wr && mode0) begin
            m0_tx_r     <= {1'b1, sfr_wdata};
            m0_tx_cnt_r <= spc_pkg::M0_LOAD;
        end else if (!mode0) begin
            m0_tx_cnt_r <= spc_pkg::M0_ZERO;
        end else if (state_six_phase_two && m0_tx_cnt_r != spc_pkg::M0_ZERO) begin
            m0_tx_cnt_r <= m0_tx_cnt_r - 4'h1;
            if (m0_tx_cnt_r != spc_pkg::M0_LOAD) begin
                m0_out_r <= m0_tx_r[0];
                m0_tx_r  <= {1'b0, m0_tx_r[8:1]};
            end
        end
    end

    // ==========================================
    // mode 0 receive: started only by a control register write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            m0_rx_r     <= 8'h00;
            m0_rx_cnt_r <= spc_pkg::M0_ZERO;
        end else if (ctrl_wr && m0_rx_cnt_r == spc_pkg::M0_ZERO
                     && sfr_wdata[spc_pkg::CTL_SMH:spc_pkg::CTL_SML] == spc_pkg::MODE_SYNC
                     && sfr_wdata[spc_pkg::CTL_REN] && !sfr_wdata[spc_pkg::CTL_RI]) begin
            m0_rx_cnt_r <= spc_pkg::M0_LOAD + spc_pkg::M0_ONE;
        end else if (!mode0 || !ctrl_r[spc_pkg::CTL_REN]) begin
            m0_rx_cnt_r <= spc_pkg::M0_ZERO;
        end else if (state_six_phase_two && m0_rx_cnt_r > spc_pkg::M0_ONE) begin
            m0_rx_cnt_r <= m0_rx_cnt_r - 4'h1;
            if (m0_rx_cnt_r <= spc_pkg::M0_RX_CLK) begin
                m0_rx_r <= {rxd_in, m0_rx_r[7:1]};
            end
        end else if (state_one_phase_one && m0_rx_cnt_r == spc_pkg::M0_ONE) begin
            m0_rx_cnt_r <= spc_pkg::M0_ZERO;
        end
    end

    // ==========================================
    // mode 0 shift clock on the transmit pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_clock_out_r <= 1'b1;
        end else if (s3_to_s5 && m0_tx_cnt_r >= spc_pkg::M0_ONE
                     && m0_tx_cnt_r <= spc_pkg::M0_TX_CLK) begin
            shift_clock_out_r <= 1'b0;
        end else if (s3_to_s5 && m0_rx_cnt_r >= spc_pkg::M0_RX_END
                     && m0_rx_cnt_r <= spc_pkg::M0_RX_CLK) begin
            shift_clock_out_r <= 1'b0;
        end else begin
            shift_clock_out_r <= 1'b1;
        end
    end

    // ==========================================
    // baud generator ticks, sixteen per bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            m2_div_r <= 2'h0;
        end else if (brg_tick || mode != spc_pkg::MODE_A11F) begin
            m2_div_r <= 2'h0;
        end else begin
            m2_div_r <= m2_div_r + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_half_r <= 1'b0;
        end else if (timer1_overflow) begin
            ovf_half_r <= ~ovf_half_r;
        end
    end

    always_comb begin
        brg_tick = 1'b0;
        unique case (mode)
            spc_pkg::MODE_SYNC: brg_tick = 1'b0;
            spc_pkg::MODE_A11F: brg_tick = (m2_div_r == (baud_doubler_bit ?
                                           spc_pkg::M2_FAST : spc_pkg::M2_SLOW));
            spc_pkg::MODE_A10,
            spc_pkg::MODE_A11T: brg_tick = timer1_overflow
                                           && (baud_doubler_bit || ovf_half_r);
        endcase
    end

    // ==========================================
    // asynchronous transmit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx16_r <= 4'h0;
        end else if (brg_tick) begin
            tx16_r <= tx16_r + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_tx_r      <= 11'h000;
            a_tx_bits_r <= 4'h0;
            a_txd_r     <= 1'b1;
        end else if (data_wr && !mode0) begin
            a_tx_r      <= (mode == spc_pkg::MODE_A10) ? {2'b01, sfr_wdata, 1'b0}
                         : {1'b1, ctrl_r[spc_pkg::CTL_TB8], sfr_wdata, 1'b0};
            a_tx_bits_r <= (mode == spc_pkg::MODE_A10) ? spc_pkg::A10_BITS : spc_pkg::A11_BITS;
        end else if (mode0) begin
            a_tx_bits_r <= 4'h0;
            a_txd_r     <= 1'b1;
        end else if (brg_tick && tx16_r == spc_pkg::BIT_LAST && a_tx_bits_r != 4'h0) begin
            a_txd_r     <= a_tx_r[0];
            a_tx_r      <= {1'b0, a_tx_r[10:1]};
            a_tx_bits_r <= a_tx_bits_r - 4'h1;
        end
    end

    // ==========================================
    // asynchronous receive with two of three sampling
    assign bit_v    = maj3({samp_r, rxd_in});
    assign stop_idx = (mode == spc_pkg::MODE_A10) ? spc_pkg::STOP_A10 : spc_pkg::STOP_A11;
    assign key_bit  = (mode == spc_pkg::MODE_A10) ? bit_v : a_rx_r[8];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_r   <= spc_pkg::RX_IDLE;
            rx16_r    <= 4'h0;
            rx_idx_r  <= 4'h0;
            samp_r    <= 2'h0;
            a_rx_r    <= 9'h000;
            rx_prev_r <= 1'b1;
        end else if (mode0 || !ctrl_r[spc_pkg::CTL_REN]) begin
            rx_st_r <= spc_pkg::RX_IDLE;
        end else if (brg_tick) begin
            rx_prev_r <= rxd_in;
            unique case (rx_st_r)
                spc_pkg::RX_IDLE: begin
                    if (rx_prev_r && !rxd_in) begin
                        rx_st_r  <= spc_pkg::RX_FRAME;
                        rx16_r   <= 4'h0;
                        rx_idx_r <= 4'h0;
                    end
                end
                spc_pkg::RX_FRAME: begin
                    rx16_r <= rx16_r + 4'h1;
                    if (rx16_r >= spc_pkg::SAMP_A && rx16_r < spc_pkg::SAMP_C) begin
                        samp_r <= {samp_r[0], rxd_in};
                    end
                    if (rx16_r == spc_pkg::SAMP_C) begin
                        if ((rx_idx_r == 4'h0 && bit_v) || rx_idx_r == stop_idx) begin
                            rx_st_r <= spc_pkg::RX_IDLE;
                        end else if (rx_idx_r != 4'h0) begin
                            a_rx_r <= {bit_v, a_rx_r[8:1]};
                        end
                        rx_idx_r <= rx_idx_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // completion events
    always_comb begin
        ti_set   = 1'b0;
        ri_set   = 1'b0;
        rb8_set  = 1'b0;
        rb8_val  = 1'b0;
        buf_load = 1'b0;
        buf_val  = m0_rx_r;
        if (mode0) begin
            ti_set   = state_six_phase_two && m0_tx_cnt_r == spc_pkg::M0_ONE;
            buf_load = state_six_phase_two && m0_rx_cnt_r == spc_pkg::M0_RX_END;
            buf_val  = {rxd_in, m0_rx_r[7:1]};
            ri_set   = state_one_phase_one && m0_rx_cnt_r == spc_pkg::M0_ONE;
        end else begin
            ti_set = brg_tick && tx16_r == spc_pkg::BIT_LAST
                     && a_tx_bits_r == 4'h1;
            if (brg_tick && rx_st_r == spc_pkg::RX_FRAME && rx16_r == spc_pkg::SAMP_C
                && rx_idx_r == stop_idx && !ctrl_r[spc_pkg::CTL_RI]
                && (!ctrl_r[spc_pkg::CTL_SM2] || key_bit)) begin
                ri_set   = 1'b1;
                buf_load = 1'b1;
                buf_val  = (mode == spc_pkg::MODE_A10) ? a_rx_r[8:1] : a_rx_r[7:0];
                rb8_set  = (mode != spc_pkg::MODE_A10) || !ctrl_r[spc_pkg::CTL_SM2];
                rb8_val  = key_bit;
            end
        end
    end

    // ==========================================
    // pins
    assign rxd_out = m0_out_r;
    assign rxd_oe  = mode0 && (m0_rx_cnt_r == spc_pkg::M0_ZERO);
    assign txd_out = mode0 ? shift_clock_out_r : a_txd_r;
endmodule // spc_serial_port

// File: bench/spc_serial_port_checker.sv
// assertions on the serial port register port and pins
// assumes one clock ref_clk and the active low reset rst_n
module spc_serial_port_checker (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // pins
    input wire logic       rxd_out,
    input wire logic       rxd_oe,
    input wire logic       txd_out,
    input wire logic       serial_irq
);
    // ========
    // helper state
    logic [1:0] mode_r;
    logic [3:0] rise_r;
    logic [4:0] gap_r;
    logic       seen_r;
    logic       m0;
    logic       ctl_wr;
    assign ctl_wr = sfr_wr && (sfr_addr == spc_pkg::CTRL_ADDR);
    assign m0     = (mode_r == spc_pkg::MODE_SYNC);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= spc_pkg::MODE_SYNC;
            rise_r <= 4'h0;
            gap_r  <= 5'h00;
            seen_r <= 1'b0;
        end else begin
            mode_r <= ctl_wr ? sfr_wdata[7:6] : mode_r;
            rise_r <= sfr_wr ? 4'h0 : rise_r + 4'(m0 && $rose(txd_out));
            gap_r  <= $changed(txd_out) ? 5'h01 : gap_r + 5'h01;
            seen_r <= !sfr_wr && (seen_r || $changed(txd_out));
        end
    end
    // ========
    // assertions
    chk_reset_pins: assert property (
        $rose(rst_n) |-> !serial_irq && txd_out && rxd_out && rxd_oe)
        else $error("pins not idle after reset");
    chk_irq_flags: assert property (
        sfr_rd && sfr_addr == spc_pkg::CTRL_ADDR |=>
        $past(serial_irq) == (sfr_rdata[spc_pkg::CTL_RI] | sfr_rdata[spc_pkg::CTL_TI]))
        else $error("request does not match flags");
    chk_unmapped_read: assert property (
        sfr_rd && sfr_addr != spc_pkg::CTRL_ADDR && sfr_addr != spc_pkg::DATA_ADDR
        |=> sfr_rdata == spc_pkg::READ_NONE)
        else $error("unmapped read not zero");
    chk_clk_low: assert property (
        m0 && $fell(txd_out) |-> (!txd_out)[*6] ##1 txd_out)
        else $error("shift clock low phase wrong");
    chk_clk_high: assert property (
        m0 && $rose(txd_out) && rise_r < 4'h7 |-> txd_out[*6] ##1 !txd_out)
        else $error("shift clock period wrong");
    chk_last_flag: assert property (
        m0 && $rose(txd_out) && rise_r == 4'h7 |-> ##[1:2] serial_irq)
        else $error("no flag after eighth clock");
    chk_rx_release: assert property (
        m0 && ctl_wr && rxd_oe && sfr_wdata[7:6] == spc_pkg::MODE_SYNC
        && sfr_wdata[spc_pkg::CTL_REN] && !sfr_wdata[spc_pkg::CTL_RI] |=> !rxd_oe)
        else $error("receive did not start");
    chk_async_oe: assert property (
        !m0 && !$past(ctl_wr) |-> !rxd_oe)
        else $error("receive pin driven in async mode");
    chk_m2_bit: assert property (
        mode_r == spc_pkg::MODE_A11F && seen_r && $changed(txd_out) |-> gap_r == 5'h00)
        else $error("mode 2 bit length wrong");
endmodule // spc_serial_port_checker

bind spc_serial_port spc_serial_port_checker i_chk (
    .ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .rxd_out, .rxd_oe, .txd_out, .serial_irq
);

// File: bench/spc_shift_partner.sv
// external shift register on the mode 0 pins
// assumes the shift clock on txd and data on the receive line
module spc_shift_partner (
    // clock
    input wire logic       ref_clk,
    // mode 0 pins
    input wire logic       shift_clock_out,
    input wire logic       line,
    output logic           drive,
    // bench control
    input wire logic       load,
    input wire logic [7:0] load_val,
    output logic     [7:0] captured,
    output logic     [3:0] pulses
);
    logic       shift_clock_out_r;
    logic [7:0] sreg_r;
    initial begin
        shift_clock_out_r  = 1'b1;
        sreg_r   = 8'h00;
        drive    = 1'b1;
        captured = 8'h00;
        pulses   = 4'h0;
    end
    always @(posedge ref_clk) begin
        shift_clock_out_r <= shift_clock_out;
        if (load) begin
            sreg_r <= load_val;
            pulses <= 4'h0;
        end else if (shift_clock_out_r && !shift_clock_out) begin
            drive  <= sreg_r[0];
            sreg_r <= {1'b0, sreg_r[7:1]};
        end else if (!shift_clock_out_r && shift_clock_out) begin
            captured <= {line, captured[7:1]};
            pulses   <= pulses + 4'h1;
            drive    <= ~drive;
        end
    end
endmodule // spc_shift_partner

// File: bench/spc_serial_port_tb_top.sv
// self-checking bench for the serial port
// assumes the shift register partner model and the bound checker
module spc_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // signals
    logic       ref_clk          = 1'b0;
    logic       rst_n            = 1'b0;
    logic [7:0] sfr_addr         = 8'h00;
    logic       sfr_wr           = 1'b0;
    logic       sfr_rd           = 1'b0;
    logic [7:0] sfr_wdata        = 8'h00;
    logic       baud_doubler_bit = 1'b0;
    logic       timer1_overflow  = 1'b0;
    logic       p_load           = 1'b0;
    logic [7:0] p_val            = 8'h00;
    logic       sr_sel           = 1'b0;
    logic       ser_line         = 1'b1;
    logic [1:0] ovf_cnt          = 2'h0;
    logic [7:0] sfr_rdata;
    logic       rxd_in;
    logic       rxd_out;
    logic       rxd_oe;
    logic       txd_out;
    logic       serial_irq;
    logic       p_drive;
    logic [7:0] p_cap;
    logic [3:0] p_pulses;
    int         bad_count        = 0;
    int         cmp_count        = 0;
    int         seed             = 32'h0ece;
    always #5 ref_clk = ~ref_clk;
    assign rxd_in = rxd_oe ? rxd_out : (sr_sel ? p_drive : ser_line);
    always @(posedge ref_clk) begin
        #1;
        ovf_cnt = ovf_cnt + 2'h1;
        timer1_overflow = (ovf_cnt == 2'h0);
    end
    spc_serial_port i_dut (
        .ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .baud_doubler_bit, .timer1_overflow, .rxd_in, .rxd_out, .rxd_oe,
        .txd_out, .serial_irq
    );
    spc_shift_partner i_partner (
        .ref_clk, .shift_clock_out(txd_out), .line(rxd_in), .drive(p_drive),
        .load(p_load), .load_val(p_val), .captured(p_cap), .pulses(p_pulses)
    );
    // ========
    // tasks and expectations
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_rd = 1'b0;
        check(sfr_rdata, exp, what);
    endtask
    task automatic wait_for(input bit on_txd, input int lim, output int n);
        n = 0;
        while ((on_txd ? !txd_out : serial_irq) !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > lim) begin
                bad_count++;
                $display("unexpected at %0t: wait ran out", $time);
                end_of_test();
            end
        end
    endtask
    task automatic load_partner(input logic [7:0] v);
        p_val  = v;
        p_load = 1'b1;
        @(posedge ref_clk);
        #1;
        p_load = 1'b0;
    endtask
    function automatic logic [10:0] frame(input logic [1:0] m, input logic [7:0] d,
                                          input logic b9);
        if (m == spc_pkg::MODE_A10) return {2'b11, d, 1'b0};
        return {1'b1, b9, d, 1'b0};
    endfunction
    function automatic int bit_len(input logic [1:0] m, input logic dbl);
        if (m == spc_pkg::MODE_A11F) return dbl ? 32 : 64;
        return dbl ? 64 : 128;
    endfunction
    // ========
    // main sequence
    initial begin
        logic [7:0]  d;
        logic [10:0] f;
        logic [1:0]  m;
        logic        b9;
        logic        s2;
        logic        ri;
        int          n;
        int          p;
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        rdchk(spc_pkg::CTRL_ADDR, spc_pkg::CTRL_RESET, "control after reset");
        rdchk(8'h97, spc_pkg::READ_NONE, "unmapped read");
        $display("reset test done");
        // ========
        // mode 0 transmit
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            load_partner(8'h00);
            wr(spc_pkg::CTRL_ADDR, 8'h00);
            wr(spc_pkg::DATA_ADDR, d);
            wait_for(1'b0, 200, n);
            check(p_cap, d, "shifted byte");
            check({4'h0, p_pulses}, 8'h08, "clock pulses");
            check({7'h00, rxd_out}, 8'h01, "line after word");
            rdchk(spc_pkg::CTRL_ADDR, 8'h02, "transmit flag");
        end
        $display("mode 0 transmit test done");
        // ========
        // mode 0 receive
        d = 8'($random(seed));
        load_partner(d);
        sr_sel = 1'b1;
        wr(spc_pkg::CTRL_ADDR, 8'h00);
        repeat (150) @(posedge ref_clk);
        #1;
        check({p_pulses, 3'h0, serial_irq}, 8'h00, "receive while disabled");
        wr(spc_pkg::CTRL_ADDR, 8'h10);
        wait_for(1'b0, 200, n);
        check(8'(n >= 108 && n <= 121), 8'h01, "receive flag timing");
        rdchk(spc_pkg::DATA_ADDR, d, "received byte");
        rdchk(spc_pkg::CTRL_ADDR, 8'h11, "receive flag");
        repeat (200) @(posedge ref_clk);
        rdchk(spc_pkg::CTRL_ADDR, 8'h11, "flag held");
        check({4'h0, p_pulses}, 8'h08, "single reception");
        sr_sel = 1'b0;
        wr(spc_pkg::CTRL_ADDR, 8'h00);
        check({7'h00, serial_irq}, 8'h00, "flag cleared by write");
        $display("mode 0 receive test done");
        // ========
        // mode 2 transmit at both rates
        for (int i = 0; i < 2; i++) begin
            d  = 8'($random(seed));
            b9 = 1'($random(seed));
            baud_doubler_bit = i[0];
            p = bit_len(spc_pkg::MODE_A11F, i[0]);
            f = frame(spc_pkg::MODE_A11F, d, b9);
            wr(spc_pkg::CTRL_ADDR, {spc_pkg::MODE_A11F, 2'b00, b9, 3'b000});
            wr(spc_pkg::DATA_ADDR, d);
            wait_for(1'b1, 1200, n);
            repeat (p / 2) @(posedge ref_clk);
            #1;
            for (int k = 0; k < 11; k++) begin
                check({7'h00, txd_out}, {7'h00, f[k]}, "frame bit");
                repeat (p) @(posedge ref_clk);
                #1;
            end
            rdchk(spc_pkg::CTRL_ADDR, {spc_pkg::MODE_A11F, 2'b00, b9, 3'b010}, "flag");
        end
        $display("mode 2 transmit test done");
        // ========
        // asynchronous receive with and without filter
        for (int i = 0; i < 4; i++) begin
            m  = (i < 2) ? spc_pkg::MODE_A11T : (i == 2) ? spc_pkg::MODE_A10 : spc_pkg::MODE_A11F;
            b9 = (i == 1);
            s2 = (i < 2);
            baud_doubler_bit = (i != 2);
            d  = 8'($random(seed));
            p  = bit_len(m, baud_doubler_bit);
            f  = frame(m, d, b9);
            ri = !(s2 && !b9);
            wr(spc_pkg::CTRL_ADDR, {m, s2, 5'h10});
            repeat (2 * p) @(posedge ref_clk);
            #1;
            for (int k = 0; k < 11; k++) begin
                ser_line = f[k];
                repeat (p) @(posedge ref_clk);
                #1;
            end
            rdchk(spc_pkg::CTRL_ADDR, {m, s2, 2'b10, ri && (b9 || m == spc_pkg::MODE_A10),
                  1'b0, ri}, "receive flags");
            if (ri) rdchk(spc_pkg::DATA_ADDR, d, "async byte");
        end
        $display("async receive test done");
        end_of_test();
    end
endmodule // spc_serial_port_tb_top
